/* File: rtl/ptc_pkg.sv */
package ptc_pkg;

    // ****************************************************
    // Widths and table geometry
    // ****************************************************
    localparam int PTC_PIX_W = 12;
    localparam int PTC_NCHAN = 3;
    localparam int PTC_NPOINT = 257;
    localparam int PTC_IDX_W = 9;
    localparam int PTC_FRAC_W = 8;
    localparam int PTC_SEG_MSB = 11;
    localparam int PTC_SEG_LSB = 4;
    localparam int PTC_GAM_MSB = 11;
    localparam int PTC_GAM_LSB = 8;
    localparam int PTC_NGAM_PT = 17;
    localparam int PTC_NGAMMA = 9;
    localparam logic [PTC_IDX_W-1:0] PTC_LAST_POINT = 9'h100;
    localparam logic [1:0] PTC_LAST_CHAN = 2'h2;
    localparam logic [3:0] PTC_LAST_GAMMA = 4'h8;
    localparam logic [PTC_PIX_W-1:0] PTC_PIX_MAX = 12'hFFF;
    localparam logic [PTC_PIX_W-1:0] PTC_PIX_ZERO = 12'h000;
    localparam logic [PTC_FRAC_W-1:0] PTC_FRAC_ZERO = 8'h00;
    localparam logic [3:0] PTC_FRAC_PAD = 4'h0;
    localparam int PTC_TAB_STEP = 16;
    localparam int PTC_GAM_STEPS = 16;
    localparam int PTC_LATENCY = 2;

    // ****************************************************
    // Modes and carriers
    // ****************************************************
    typedef enum logic [1:0] {
        PTC_MODE_OFF = 2'b00,
        PTC_MODE_GAMMA = 2'b01,
        PTC_MODE_TABLE = 2'b10
    } ptc_mode_type;

    typedef logic [PTC_PIX_W-1:0] ptc_level_type;

    typedef struct packed {
        logic valid;
        ptc_level_type [PTC_NCHAN-1:0] chan;
    } ptc_pixel_type;

    typedef struct packed {
        logic write;
        logic [1:0] channel;
        logic [PTC_IDX_W-1:0] index;
        ptc_level_type value;
    } ptc_point_wr_type;

    // ****************************************************
    // Elaboration-time curve values
    // ****************************************************
    function automatic real ptc_gamma_exp(input int g);
        case (g)
            0: return 0.45;
            1: return 0.5;
            2: return 0.55;
            3: return 0.6;
            4: return 0.65;
            5: return 0.75;
            6: return 0.8;
            7: return 0.9;
            default: return 1.0;
        endcase
    endfunction

    function automatic ptc_level_type ptc_gamma_point(input int g, input int k);
        real x;
        x = real'(k) / real'(PTC_GAM_STEPS);
        return ptc_level_type'(int'(4095.0 * (x ** ptc_gamma_exp(g))));
    endfunction

    function automatic ptc_level_type ptc_ident_point(input int k);
        return (k * PTC_TAB_STEP > int'(PTC_PIX_MAX)) ? PTC_PIX_MAX
                                                      : ptc_level_type'(k * PTC_TAB_STEP);
    endfunction

endpackage

/* File: rtl/ptc_interp.sv */
`timescale 1ns/1ns
module ptc_interp
    import ptc_pkg::*;
(
    // Neighbouring points
    input wire ptc_level_type lo,
    input wire ptc_level_type hi,
    // Position between them, in 256ths
    input wire logic [PTC_FRAC_W-1:0] frac,
    // Result
    output ptc_level_type level
);

    logic signed [PTC_PIX_W:0] diff;
    logic signed [PTC_PIX_W+PTC_FRAC_W+1:0] prod;
    logic signed [PTC_PIX_W+PTC_FRAC_W+1:0] step;
    logic signed [PTC_PIX_W+1:0] sum;

    // Result always lies between lo and hi, so never leaves 0..4095
    always_comb begin
        diff = $signed({1'b0, hi}) - $signed({1'b0, lo});
        prod = diff * $signed({1'b0, frac});
        step = prod >>> PTC_FRAC_W;
        sum = $signed({2'b00, lo}) + step[PTC_PIX_W+1:0];
        level = sum[PTC_PIX_W-1:0];
    end

endmodule

/* File: rtl/ptc_curve.sv */
`timescale 1ns/1ns
module ptc_curve
    import ptc_pkg::*;
(
    // Clock and reset
    input wire logic clock,
    input wire logic nrst,
    // Pixel stream in and out
    input wire ptc_pixel_type pix_in,
    output ptc_pixel_type pix_out,
    // Tone control group settings
    input wire logic [1:0] curve_mode_select,
    input wire logic [3:0] gamma_select,
    // Point table access
    input wire logic [1:0] curve_channel_select,
    input wire logic [PTC_IDX_W-1:0] curve_point_index,
    input wire ptc_level_type curve_point_value,
    input wire logic curve_point_write,
    output ptc_level_type curve_point_readback
);

    // ****************************************************
    // Fixed gamma curves
    // ****************************************************
    ptc_level_type gam_rom [PTC_NGAMMA][PTC_NGAM_PT];

    genvar gg, gk;
    generate
        for (gg = 0; gg < PTC_NGAMMA; gg++) begin : g_gam
            for (gk = 0; gk < PTC_NGAM_PT; gk++) begin : g_pt
                localparam ptc_level_type GVAL = ptc_gamma_point(gg, gk);
                assign gam_rom[gg][gk] = GVAL;
            end
        end
    endgenerate

    // Clamp an out-of-list exponent selection to 1.0
    function automatic logic [3:0] gam_sel(input logic [3:0] s);
        return (s > PTC_LAST_GAMMA) ? PTC_LAST_GAMMA : s;
    endfunction

    function automatic logic point_ok(input logic [1:0] ch, input logic [PTC_IDX_W-1:0] ix);
        return (ch <= PTC_LAST_CHAN) && (ix <= PTC_LAST_POINT);
    endfunction

    // ****************************************************
    // Point table
    // ****************************************************
    ptc_level_type tab_r [PTC_NCHAN][PTC_NPOINT];
    ptc_point_wr_type wr;

    assign wr = '{write: curve_point_write, channel: curve_channel_select,
                  index: curve_point_index, value: curve_point_value};

    always_ff @(posedge clock) begin
        if (!nrst) begin
            for (int c = 0; c < PTC_NCHAN; c++) begin
                for (int k = 0; k < PTC_NPOINT; k++) begin
                    tab_r[c][k] <= ptc_ident_point(k);
                end
            end
        end else if (wr.write && point_ok(wr.channel, wr.index)) begin
            tab_r[wr.channel][wr.index] <= wr.value;
        end
    end

    always_ff @(posedge clock) begin
        if (!nrst) begin
            curve_point_readback <= PTC_PIX_ZERO;
        end else if (point_ok(curve_channel_select, curve_point_index)) begin
            curve_point_readback <= tab_r[curve_channel_select][curve_point_index];
        end else begin
            curve_point_readback <= PTC_PIX_ZERO;
        end
    end

    // ****************************************************
    // Stage 1: pick neighbouring points
    // ****************************************************
    ptc_mode_type mode;
    logic [3:0] gsel;
    ptc_level_type lo_r [PTC_NCHAN];
    ptc_level_type hi_r [PTC_NCHAN];
    logic [PTC_FRAC_W-1:0] frac_r [PTC_NCHAN];
    logic valid1_r;
    ptc_level_type level [PTC_NCHAN];

    assign mode = ptc_mode_type'(curve_mode_select);
    assign gsel = gam_sel(gamma_select);

    always_ff @(posedge clock) begin
        if (!nrst) begin
            valid1_r <= 1'b0;
        end else begin
            valid1_r <= pix_in.valid;
        end
    end

    genvar gc;
    generate
        for (gc = 0; gc < PTC_NCHAN; gc++) begin : g_chan
            logic [7:0] seg;
            logic [3:0] gseg;
            logic [PTC_IDX_W-1:0] seg_hi;
            logic [4:0] gseg_hi;

            assign seg = pix_in.chan[gc][PTC_SEG_MSB:PTC_SEG_LSB];
            assign gseg = pix_in.chan[gc][PTC_GAM_MSB:PTC_GAM_LSB];
            assign seg_hi = {1'b0, seg} + 9'h001;
            assign gseg_hi = {1'b0, gseg} + 5'h01;

            always_ff @(posedge clock) begin
                if (!nrst) begin
                    lo_r[gc] <= PTC_PIX_ZERO;
                    hi_r[gc] <= PTC_PIX_ZERO;
                    frac_r[gc] <= PTC_FRAC_ZERO;
                end else begin
                    case (mode)
                        PTC_MODE_TABLE: begin
                            lo_r[gc] <= tab_r[gc][seg];
                            hi_r[gc] <= tab_r[gc][seg_hi];
                            frac_r[gc] <= {pix_in.chan[gc][PTC_SEG_LSB-1:0], PTC_FRAC_PAD};
                        end
                        PTC_MODE_GAMMA: begin
                            lo_r[gc] <= gam_rom[gsel][gseg];
                            hi_r[gc] <= gam_rom[gsel][gseg_hi];
                            frac_r[gc] <= pix_in.chan[gc][PTC_GAM_LSB-1:0];
                        end
                        default: begin
                            lo_r[gc] <= pix_in.chan[gc];
                            hi_r[gc] <= pix_in.chan[gc];
                            frac_r[gc] <= PTC_FRAC_ZERO;
                        end
                    endcase
                end
            end

            ptc_interp u_interp (
                .lo(lo_r[gc]),
                .hi(hi_r[gc]),
                .frac(frac_r[gc]),
                .level(level[gc])
            );

            // ****************************************************
            // Stage 2: interpolated output
            // ****************************************************
            always_ff @(posedge clock) begin
                if (!nrst) begin
                    pix_out.chan[gc] <= PTC_PIX_ZERO;
                end else begin
                    pix_out.chan[gc] <= level[gc];
                end
            end

            // Output between the two chosen points
            chk_interp_bounds: assert property (@(posedge clock) disable iff (!nrst)
                1'b1 |=> (pix_out.chan[gc] >= (($past(lo_r[gc]) < $past(hi_r[gc]))
                              ? $past(lo_r[gc]) : $past(hi_r[gc])))
                       && (pix_out.chan[gc] <= (($past(lo_r[gc]) < $past(hi_r[gc]))
                              ? $past(hi_r[gc]) : $past(lo_r[gc]))))
                else $error("interpolated value outside its segment");

            // Bypass returns the same level two cycles later
            chk_bypass_pass: assert property (@(posedge clock) disable iff (!nrst)
                (mode == PTC_MODE_OFF) |-> ##2
                (pix_out.chan[gc] == $past(pix_in.chan[gc], PTC_LATENCY)))
                else $error("bypass altered the pixel");

            // Dark input in table mode yields point 0
            chk_table_dark: assert property (@(posedge clock) disable iff (!nrst)
                (mode == PTC_MODE_TABLE && pix_in.chan[gc] == PTC_PIX_ZERO
                 && !curve_point_write)
                |-> ##2 (pix_out.chan[gc] == $past(tab_r[gc][0], PTC_LATENCY)))
                else $error("dark level not mapped to first point");

            // Gamma maps dark to dark
            chk_gamma_dark: assert property (@(posedge clock) disable iff (!nrst)
                (mode == PTC_MODE_GAMMA && pix_in.chan[gc] == PTC_PIX_ZERO)
                |-> ##2 (pix_out.chan[gc] == PTC_PIX_ZERO))
                else $error("gamma did not map dark to zero");

            // Exact point hit in table mode
            chk_table_point: assert property (@(posedge clock) disable iff (!nrst)
                (mode == PTC_MODE_TABLE && pix_in.chan[gc][PTC_SEG_LSB-1:0] == 4'h0
                 && !curve_point_write)
                |-> ##2 (pix_out.chan[gc] ==
                    $past(tab_r[gc][pix_in.chan[gc][PTC_SEG_MSB:PTC_SEG_LSB]], PTC_LATENCY)))
                else $error("point level not mapped to its table value");
        end
    endgenerate

    always_ff @(posedge clock) begin
        if (!nrst) begin
            pix_out.valid <= 1'b0;
        end else begin
            pix_out.valid <= valid1_r;
        end
    end

    // ****************************************************
    // Checks
    // ****************************************************
    sequence s_take;
        pix_in.valid;
    endsequence

    sequence s_emit;
        ##2 pix_out.valid;
    endsequence

    chk_valid_latency: assert property (@(posedge clock) disable iff (!nrst)
        s_take |-> s_emit)
        else $error("pixel not delivered after two cycles");

    chk_no_spurious: assert property (@(posedge clock) disable iff (!nrst)
        !pix_in.valid ##1 1'b1 |=> !pix_out.valid)
        else $error("output valid without input");

    chk_point_store: assert property (@(posedge clock) disable iff (!nrst)
        (curve_point_write && point_ok(curve_channel_select, curve_point_index))
        ##1 (point_ok(curve_channel_select, curve_point_index)
             && curve_channel_select == $past(curve_channel_select)
             && curve_point_index == $past(curve_point_index)
             && !curve_point_write)
        |=> (curve_point_readback == $past(curve_point_value, 2)))
        else $error("written point not read back");

    chk_gamma_top: assert property (@(posedge clock) disable iff (!nrst)
        (mode == PTC_MODE_GAMMA && gsel == PTC_LAST_GAMMA
         && pix_in.chan[0][PTC_GAM_LSB-1:0] == PTC_FRAC_ZERO)
        |-> ##2 (pix_out.chan[0] ==
            $past(gam_rom[PTC_LAST_GAMMA][pix_in.chan[0][PTC_GAM_MSB:PTC_GAM_LSB]],
                  PTC_LATENCY)))
        else $error("gamma point not applied");

    chk_bad_index: assert property (@(posedge clock) disable iff (!nrst)
        !point_ok(curve_channel_select, curve_point_index)
        |=> (curve_point_readback == PTC_PIX_ZERO))
        else $error("readback for out-of-range point not zero");

endmodule

/* File: tb/ptc_sensor_model.sv */
`timescale 1ns/1ns
// ****************************************************
// Upstream sensor pixel path
// ****************************************************
module ptc_sensor_model
    import ptc_pkg::*;
(
    // Clock
    input wire logic clock,
    // Request from the bench
    input wire logic send,
    input wire ptc_level_type [PTC_NCHAN-1:0] level,
    // Pixel stream towards the curve
    output ptc_pixel_type pix
);
    initial pix = '0;
    // Idle lines toggle so stale data never looks like a pixel
    always @(posedge clock) begin
        pix.valid <= send;
        pix.chan <= send ? level : ~pix.chan;
    end
endmodule

/* File: tb/testbench.sv */
`timescale 1ns/1ns
module testbench
    import ptc_pkg::*;
();
    logic clock = 1'b0;
    logic nrst = 1'b0;
    logic send = 1'b0;
    ptc_level_type [PTC_NCHAN-1:0] lvl = '0;
    ptc_pixel_type pix_in;
    ptc_pixel_type pix_out;
    logic [1:0] mode = 2'h0;
    logic [3:0] gsel = 4'h0;
    logic [1:0] csel = 2'h0;
    logic [PTC_IDX_W-1:0] pidx = 9'h000;
    ptc_level_type pval = 12'h000;
    logic pwr = 1'b0;
    ptc_level_type rb;
    int fail_count = 0;
    int total_checks = 0;
    logic [31:0] rng = 32'h00005384;
    ptc_level_type tab [3][257];
    ptc_pixel_type hist [3];
    real gexp [9] = '{0.45, 0.5, 0.55, 0.6, 0.65, 0.75, 0.8, 0.9, 1.0};

    always #4 clock = ~clock;

    ptc_sensor_model u_ptc_sensor_model (.clock(clock), .send(send), .level(lvl), .pix(pix_in));

    ptc_curve u_ptc_curve (
        .clock(clock), .nrst(nrst), .pix_in(pix_in), .pix_out(pix_out),
        .curve_mode_select(mode), .gamma_select(gsel), .curve_channel_select(csel),
        .curve_point_index(pidx), .curve_point_value(pval), .curve_point_write(pwr),
        .curve_point_readback(rb)
    );

    // ****************************************************
    // Expectations
    // ****************************************************
    function automatic logic [31:0] rnd();
        rng ^= rng << 13;
        rng ^= rng >> 17;
        rng ^= rng << 5;
        return rng;
    endfunction

    function automatic int gpt(input int g, input int k);
        return int'(4095.0 * ((real'(k) / 16.0) ** gexp[g]));
    endfunction

    function automatic ptc_level_type expect_lvl(input logic [1:0] m, input logic [3:0] g,
                                                 input int c, input ptc_level_type x);
        int lo;
        int hi;
        int gs;
        gs = (g > 4'h8) ? 8 : int'(g);
        if (m == 2'h2) begin
            lo = tab[c][x[11:4]];
            hi = tab[c][int'(x[11:4]) + 1];
            return ptc_level_type'(lo + (hi - lo) * int'(x[3:0]) / 16);
        end
        if (m == 2'h1) begin
            lo = gpt(gs, int'(x[11:8]));
            hi = gpt(gs, int'(x[11:8]) + 1);
            return ptc_level_type'(lo + (hi - lo) * int'(x[7:0]) / 256);
        end
        return x;
    endfunction

    // ****************************************************
    // Drivers and comparison
    // ****************************************************
    task automatic check(input ptc_level_type seen, input ptc_level_type exp);
        total_checks++;
        if (seen !== exp) begin
            fail_count++;
            $display("MISMATCH t=%0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic print_verdict();
        if (fail_count == 0 && total_checks > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    task automatic cyc(input logic v, input ptc_level_type [2:0] d);
        ptc_pixel_type e;
        @(posedge clock);
        send <= v;
        lvl <= d;
        #1;
        e.valid = v;
        for (int c = 0; c < 3; c++) e.chan[c] = expect_lvl(mode, gsel, c, d[c]);
        check({11'h000, pix_out.valid}, {11'h000, hist[2].valid});
        for (int c = 0; c < 3; c++) begin
            if (hist[2].valid) check(pix_out.chan[c], hist[2].chan[c]);
        end
        hist[2] = hist[1];
        hist[1] = hist[0];
        hist[0] = e;
    endtask

    task automatic batch(input logic [1:0] m, input logic [3:0] g, input int n);
        logic [63:0] r;
        @(posedge clock);
        mode <= m;
        gsel <= g;
        cyc(1'b1, {12'hFF0, 12'h000, 12'hFFF});
        cyc(1'b1, {12'h000, 12'hFFF, 12'h00F});
        for (int i = 0; i < n; i++) begin
            r = {rnd(), rnd()};
            cyc(r[63:62] != 2'h0, r[35:0]);
        end
        repeat (3) cyc(1'b0, '0);
    endtask

    task automatic wr(input logic [1:0] c, input logic [8:0] i, input ptc_level_type v);
        logic ok;
        ok = (c <= PTC_LAST_CHAN) && (i <= PTC_LAST_POINT);
        @(posedge clock);
        csel <= c;
        pidx <= i;
        pval <= v;
        pwr <= 1'b1;
        @(posedge clock);
        pwr <= 1'b0;
        @(posedge clock);
        #1;
        if (ok) tab[c][i] = v;
        check(rb, ok ? v : 12'h000);
    endtask

    // ****************************************************
    // Main sequence
    // ****************************************************
    initial begin
        int v;
        for (int c = 0; c < 3; c++) begin
            for (int k = 0; k < 257; k++) tab[c][k] = (k == 256) ? 12'hFFF : ptc_level_type'(k * 16);
        end
        hist = '{default: '0};
        repeat (2) @(posedge clock);
        #1;
        check({pix_out.valid, pix_out.chan[0][10:0]}, 12'h000);
        check(rb, 12'h000);
        @(posedge clock);
        nrst <= 1'b1;
        batch(2'h2, 4'h0, 20);
        for (int c = 0; c < 3; c++) begin
            v = 0;
            for (int k = 0; k < 257; k++) begin
                v = v + int'(rnd() % (8 * (c + 1) + 1));
                v = (k == 256 || v > 4095) ? 4095 : v;
                wr(c[1:0], k[8:0], ptc_level_type'(v));
            end
        end
        wr(2'h3, 9'h005, 12'hFFF);
        wr(2'h0, 9'h101, 12'hABC);
        batch(2'h2, 4'h3, 60);
        batch(2'h0, 4'h0, 12);
        batch(2'h3, 4'h0, 12);
        for (int g = 0; g < 16; g++) batch(2'h1, g[3:0], 8);
        print_verdict();
    end

    initial begin
        #600000;
        fail_count++;
        print_verdict();
    end
endmodule
